// ==== sim/test_alufw_flag_writeback.sv ====
// Testbench for the ALU flag register write-back block.
// Assumes the design and package in src/ are compiled first.
`timescale 1ns/10ps
`default_nettype none

module test_alufw_flag_writeback;
  typedef struct packed {
    alufw_pkg::alufw_op_t op;
    logic [7:0] a, b;
    logic [2:0] bi;
    logic sf, df, we;
    logic [7:0] wd;
    logic [4:0] fl;
  } alufw_row_t;

  // Clock, reset and instruction inputs
  logic aclk = 1'b0, aresetn = 1'b0, exec_valid = 1'b0;
  alufw_pkg::alufw_op_t exec_op = alufw_pkg::OP_ADD;
  logic [7:0] operand_a = 8'h00, operand_b = 8'h00;
  logic [2:0] bit_index = 3'h0;
  logic src_is_flags = 1'b0, dest_is_flags = 1'b0;
  // Bus master side
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  // Design outputs
  logic wb_we, awready, wready, bvalid, arready, rvalid;
  logic [7:0] wb_data;
  logic [4:0] flags;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  int err_total = 0, cmp_count = 0;

  // Rows: op a b bit src dst -> we data flags
  alufw_row_t rows [15] = '{
    '{alufw_pkg::OP_ADD, 8'hFF, 8'h01, 3'h0, 1'b0, 1'b0, 1'b1, 8'h00, 5'h07},
    '{alufw_pkg::OP_SUB, 8'h10, 8'h01, 3'h0, 1'b0, 1'b0, 1'b1, 8'h0F, 5'h01},
    '{alufw_pkg::OP_SUB, 8'h01, 8'h02, 3'h0, 1'b0, 1'b0, 1'b1, 8'hFF, 5'h10},
    '{alufw_pkg::OP_AND, 8'hF0, 8'h0F, 3'h0, 1'b0, 1'b0, 1'b1, 8'h00, 5'h04},
    '{alufw_pkg::OP_ADD, 8'h7F, 8'h01, 3'h0, 1'b0, 1'b0, 1'b1, 8'h80, 5'h1A},
    '{alufw_pkg::OP_CLR, 8'h00, 8'h00, 3'h0, 1'b0, 1'b1, 1'b0, 8'h00, 5'h1E},
    '{alufw_pkg::OP_ADD, 8'h01, 8'h01, 3'h0, 1'b0, 1'b1, 1'b0, 8'h00, 5'h00},
    '{alufw_pkg::OP_BSET, 8'h00, 8'h00, 3'h3, 1'b1, 1'b1, 1'b0, 8'h00, 5'h08},
    '{alufw_pkg::OP_SWAP, 8'hA5, 8'h00, 3'h0, 1'b0, 1'b0, 1'b1, 8'h5A, 5'h08},
    '{alufw_pkg::OP_STOR, 8'h00, 8'h13, 3'h0, 1'b0, 1'b1, 1'b0, 8'h00, 5'h13},
    '{alufw_pkg::OP_MOVE, 8'h3C, 8'h00, 3'h0, 1'b0, 1'b0, 1'b1, 8'h3C, 5'h13},
    '{alufw_pkg::OP_BCLR, 8'h00, 8'h00, 3'h0, 1'b1, 1'b0, 1'b1, 8'h12, 5'h13},
    '{alufw_pkg::OP_SUB, 8'h35, 8'h35, 3'h0, 1'b0, 1'b0, 1'b1, 8'h00, 5'h07},
    '{alufw_pkg::OP_SUB, 8'h20, 8'h30, 3'h0, 1'b0, 1'b1, 1'b0, 8'h00, 5'h12},
    '{alufw_pkg::OP_MOVE, 8'h3C, 8'h00, 3'h0, 1'b0, 1'b1, 1'b0, 8'h00, 5'h1C}};

  alufw_flag_writeback DUT (.aclk, .aresetn, .exec_valid, .exec_op,
    .operand_a, .operand_b, .bit_index, .src_is_flags, .dest_is_flags,
    .wb_we, .wb_data, .flags, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);

  always #5 aclk = ~aclk;

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bound(input logic ok);
    if (!ok) begin
      err_total++;
      complete_run();
    end
  endtask

  task automatic run_row(input alufw_row_t r);
    @(posedge aclk);
    exec_op <= r.op;
    operand_a <= r.a;
    operand_b <= r.b;
    bit_index <= r.bi;
    src_is_flags <= r.sf;
    dest_is_flags <= r.df;
    exec_valid <= 1'b1;
    @(posedge aclk);
    exec_valid <= 1'b0;
    #1;
    chk("wb_we", 32'(r.we), 32'(wb_we));
    if (r.we)
      chk("wb_data", 32'(r.wd), 32'(wb_data));
    chk("flags", 32'(r.fl), 32'(flags));
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb && n < 40) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb)
        chk("bresp", 32'(er), 32'(bresp));
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    bound(tb);
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [1:0] er,
                        output logic [31:0] d);
    int n;
    logic ta, tr;
    n = 0;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr && n < 40) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      if (tr)
        chk("rresp", 32'(er), 32'(rresp));
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    bound(tr);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("rst flags", 32'h0, 32'(flags));
    chk("rst wb_we", 32'h0, 32'(wb_we));
    // Flag moves in rows 7, 9, 11 and 14
    foreach (rows[i])
      run_row(rows[i]);
    axi_rd(alufw_pkg::FLAGS_OFS, alufw_pkg::RESP_OKAY, rd);
    chk("rd flags", 32'h1C, rd);
    axi_wr(alufw_pkg::FLAGS_OFS, 32'h15, 4'hF, alufw_pkg::RESP_OKAY);
    axi_wr(alufw_pkg::FLAGS_OFS, 32'h0A, 4'h0, alufw_pkg::RESP_OKAY);
    axi_rd(alufw_pkg::FLAGS_OFS, alufw_pkg::RESP_OKAY, rd);
    chk("wr flags", 32'h15, rd);
    axi_wr(alufw_pkg::RESULT_OFS, 32'hFF, 4'hF, alufw_pkg::RESP_OKAY);
    axi_rd(alufw_pkg::RESULT_OFS, alufw_pkg::RESP_OKAY, rd);
    chk("result", 32'h3C, rd);
    axi_wr(4'h8, 32'h1F, 4'hF, alufw_pkg::RESP_SLVERR);
    axi_rd(4'h8, alufw_pkg::RESP_SLVERR, rd);
    chk("unmapped", 32'h0, rd);
    chk("flags kept", 32'h15, 32'(flags));
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("rerst flags", 32'h0, 32'(flags));
    complete_run();
  end
endmodule // test_alufw_flag_writeback

`default_nettype wire

// ==== src/alufw_flag_writeback.sv ====
// ALU flag register with write-back arbitration and AXI4-Lite access.
// Assumes the core issues at most one instruction per clock on exec_valid.
//
// Contract
// - The block keeps a status register with the ALU condition flags.
// - The flag register is an ordinary operand, readable and writable.
// - A flag-affecting instruction aimed at the flags drops its result.
// - A clear aimed at the flag register only sets the zero flag.
`timescale 1ns/10ps
`default_nettype none

module alufw_flag_writeback #(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Core instruction port
  input  wire logic                 exec_valid,
  input  wire alufw_pkg::alufw_op_t exec_op,
  input  wire logic [7:0]           operand_a,
  input  wire logic [7:0]           operand_b,
  input  wire logic [2:0]           bit_index,
  input  wire logic                 src_is_flags,
  input  wire logic                 dest_is_flags,
  // Write-back port
  output logic                      wb_we,
  output logic [7:0]                wb_data,
  output logic [4:0]                flags,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]    awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [ADDR_W-1:0]    araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready
);

  logic [7:0]        src_a;
  logic [7:0]        op_b;
  logic              cin;
  logic [8:0]        sum9;
  logic [4:0]        nib5;
  logic [7:0]        alu_res;
  logic [4:0]        new_flags;
  logic [4:0]        flag_mask;
  logic [4:0]        next_flags;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [4:0]        w_data;
  logic              w_lane0;
  logic              bus_wr_fire;
  logic [7:0]        last_result;

  // Source operand selection, flags usable as a source
  assign src_a = src_is_flags ? {3'h0, flags} : operand_a;

  assign op_b = (exec_op == alufw_pkg::OP_SUB) ? ~operand_b : operand_b;
  assign cin  = (exec_op == alufw_pkg::OP_SUB);
  assign sum9 = {1'b0, src_a} + {1'b0, op_b} + {8'h00, cin};
  assign nib5 = {1'b0, src_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};

  // ALU result and flag effects
  always_comb begin
    alu_res   = 8'h00;
    flag_mask = 5'h00;
    new_flags = 5'h00;
    case (exec_op)
      alufw_pkg::OP_ADD, alufw_pkg::OP_SUB: begin
        alu_res   = sum9[7:0];
        flag_mask = 5'h1F;
      end
      alufw_pkg::OP_AND: begin
        alu_res   = src_a & operand_b;
        flag_mask = 5'h14;
      end
      alufw_pkg::OP_CLR: begin
        alu_res   = 8'h00;
        flag_mask = 5'h04;
      end
      alufw_pkg::OP_BCLR: alu_res = src_a & ~(8'h01 << bit_index);
      alufw_pkg::OP_BSET: alu_res = src_a | (8'h01 << bit_index);
      alufw_pkg::OP_SWAP: alu_res = {src_a[3:0], src_a[7:4]};
      alufw_pkg::OP_MOVE: alu_res = src_a;
      alufw_pkg::OP_STOR: alu_res = operand_b;
      default:            alu_res = 8'h00;
    endcase
    new_flags[alufw_pkg::CARRY_BIT]    = sum9[8];
    new_flags[alufw_pkg::NIBBLE_BIT]   = nib5[4];
    new_flags[alufw_pkg::ZERO_BIT]     = (alu_res == 8'h00);
    new_flags[alufw_pkg::OVERFLOW_BIT] = (src_a[7] == op_b[7]) &&
                                         (alu_res[7] != src_a[7]);
    new_flags[alufw_pkg::NEG_BIT]      = alu_res[7];
  end

  // Flag register next value
  always_comb begin
    next_flags = flags;
    if (exec_valid) begin
      if (dest_is_flags && flag_mask == 5'h00) begin
        next_flags = alu_res[4:0];
      end else begin
        next_flags = (flags & ~flag_mask) | (new_flags & flag_mask);
      end
    end else if (bus_wr_fire && w_lane0 &&
                 aw_addr == alufw_pkg::FLAGS_OFS[ADDR_W-1:0]) begin
      next_flags = w_data;
    end
  end

  // Flag register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= alufw_pkg::FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wb_we       <= 1'b0;
      wb_data     <= 8'h00;
      last_result <= 8'h00;
    end else begin
      wb_we <= exec_valid && !dest_is_flags;
      if (exec_valid) begin
        wb_data     <= alu_res;
        last_result <= alu_res;
      end
    end
  end

  // AXI write channels
  assign awready     = !aw_held && !bvalid;
  assign wready      = !w_held && !bvalid;
  assign bus_wr_fire = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 5'h00;
      w_lane0 <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= alufw_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data  <= wdata[4:0];
        w_lane0 <= wstrb[0];
      end
      if (bus_wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= (aw_addr == alufw_pkg::FLAGS_OFS[ADDR_W-1:0] ||
                   aw_addr == alufw_pkg::RESULT_OFS[ADDR_W-1:0]) ?
                  alufw_pkg::RESP_OKAY : alufw_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  // AXI read channels
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= alufw_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= alufw_pkg::RESP_OKAY;
      if (araddr == alufw_pkg::FLAGS_OFS[ADDR_W-1:0]) begin
        rdata <= {27'h0000000, flags};
      end else if (araddr == alufw_pkg::RESULT_OFS[ADDR_W-1:0]) begin
        rdata <= {24'h000000, last_result};
      end else begin
        rdata <= 32'h00000000;
        rresp <= alufw_pkg::RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Assertions
  property p_add_carry;
    @(posedge aclk) disable iff (!aresetn)
    exec_valid && exec_op == alufw_pkg::OP_ADD && !dest_is_flags |=>
      flags[alufw_pkg::CARRY_BIT] == $past(sum9[8]) &&
      flags[alufw_pkg::ZERO_BIT] == ($past(alu_res) == 8'h00);
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add did not record carry or zero");

  property p_bus_flags_read;
    @(posedge aclk) disable iff (!aresetn)
    arvalid && arready && araddr == alufw_pkg::FLAGS_OFS[ADDR_W-1:0] |=>
      rvalid && rdata == {27'h0000000, $past(flags)};
  endproperty
  a_bus_flags_read: assert property (p_bus_flags_read)
    else $error("flag read returned wrong value");

  property p_plain_dest;
    @(posedge aclk) disable iff (!aresetn)
    exec_valid && dest_is_flags && exec_op == alufw_pkg::OP_MOVE |=>
      flags == $past(src_a[4:0]) && !wb_we;
  endproperty
  a_plain_dest: assert property (p_plain_dest)
    else $error("move into flags not stored");

  property p_discard;
    @(posedge aclk) disable iff (!aresetn)
    exec_valid && dest_is_flags && exec_op == alufw_pkg::OP_ADD |=>
      !wb_we && flags[alufw_pkg::NEG_BIT] == $past(sum9[7]);
  endproperty
  a_discard: assert property (p_discard)
    else $error("result written despite flag destination");

  property p_clear_flags;
    @(posedge aclk) disable iff (!aresetn)
    exec_valid && dest_is_flags && exec_op == alufw_pkg::OP_CLR |=>
      flags == ($past(flags) | 5'h04);
  endproperty
  a_clear_flags: assert property (p_clear_flags)
    else $error("clear of flags changed more than zero");

  property p_borrow;
    @(posedge aclk) disable iff (!aresetn)
    exec_valid && exec_op == alufw_pkg::OP_SUB |=>
      flags[alufw_pkg::CARRY_BIT] == ($past(src_a) >= $past(operand_b)) &&
      flags[alufw_pkg::NIBBLE_BIT] ==
        ($past(src_a[3:0]) >= $past(operand_b[3:0]));
  endproperty
  a_borrow: assert property (p_borrow)
    else $error("borrow polarity wrong");

  property p_bresp_follow;
    @(posedge aclk) disable iff (!aresetn)
    aw_held && w_held && !bvalid |=> bvalid ##0 $stable(aw_addr);
  endproperty
  a_bresp_follow: assert property (p_bresp_follow)
    else $error("write response late");

  property p_sub_dest_flags;
    @(posedge aclk) disable iff (!aresetn)
    exec_valid && dest_is_flags && exec_op == alufw_pkg::OP_SUB |=>
      !wb_we && flags[alufw_pkg::CARRY_BIT] ==
        ($past(src_a) >= $past(operand_b));
  endproperty
  a_sub_dest_flags: assert property (p_sub_dest_flags)
    else $error("subtract into flags wrote result");

  cover property (@(posedge aclk) disable iff (!aresetn)
    exec_valid && dest_is_flags && exec_op == alufw_pkg::OP_CLR);
  cover property (@(posedge aclk) disable iff (!aresetn)
    exec_valid && exec_op == alufw_pkg::OP_SUB && !sum9[8]);
  cover property (@(posedge aclk) disable iff (!aresetn)
    bus_wr_fire && aw_addr == alufw_pkg::FLAGS_OFS[ADDR_W-1:0]);

endmodule : alufw_flag_writeback

`default_nettype wire

// ==== src/alufw_pkg.sv ====
// Package: constants for the ALU flag register write-back block.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register port.
package alufw_pkg;

  // Flag field positions within the flag register
  localparam int CARRY_BIT    = 0;
  localparam int NIBBLE_BIT   = 1;
  localparam int ZERO_BIT     = 2;
  localparam int OVERFLOW_BIT = 3;
  localparam int NEG_BIT      = 4;
  localparam int FLAG_W       = 5;

  // Flag register reset value
  localparam logic [4:0] FLAGS_RESET = 5'h00;

  // Register byte offsets
  localparam logic [3:0] FLAGS_OFS  = 4'h0;
  localparam logic [3:0] RESULT_OFS = 4'h4;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Instruction classes seen by the write-back stage
  typedef enum logic [3:0] {
    OP_ADD  = 4'h0,
    OP_SUB  = 4'h1,
    OP_AND  = 4'h2,
    OP_CLR  = 4'h3,
    OP_BCLR = 4'h4,
    OP_BSET = 4'h5,
    OP_SWAP = 4'h6,
    OP_MOVE = 4'h7,
    OP_STOR = 4'h8
  } alufw_op_t;

endpackage : alufw_pkg
